//--- verilog/tpw_pkg.sv
// Package: register map, field layout and constants of the 8-bit period/PWM timer
//
// Operation
// - The upper four bits of the control register choose the timer clock source from system clock, fast RC, slow RC, crystal, two port pins or the comparator.
// - With the fast RC as source, timer ticks keep coming while the processor is halted by an emulator.
// - Control bits 3 down to 2 route the timer output to one of three port pins.
// - A prescaler divides the chosen clock by 1, 4, 16 or 64 as scaling bits 6 down to 5 select.
// - A scaler then divides by scaling bits 4 down to 0 plus one, from 1 to 32.
// - The counter is 8 bits, counts up only, and software can write and read it.
// - In period mode the counter returns to zero when it reaches the upper bound.
// - The upper bound sets the period in period mode and the duty in PWM mode.
// - Period mode gives a periodic output and event; PWM mode gives 6, 7 or 8-bit PWM.
// - Period mode output is a 50% square wave at clock over 2 times bound+1 times prescale times scale+1.
// - 8-bit PWM applies when control bit 1 is set and scaling bit 7 is clear.
// - 8-bit PWM runs at clock over 256 times prescale times scale+1, high for bound+1 of 256 steps.
// - With the comparator gate option, PWM output is held off while the comparator is 1.
// - 6-bit PWM applies when control bit 1 and scaling bit 7 are both set, with 64 steps.
// - A build option turns 6-bit PWM into 7-bit PWM with 128 steps.
package tpw_pkg;

    // Register bus widths
    localparam int unsigned TPW_AW = 3;
    localparam int unsigned TPW_DW = 8;

    // Register indices
    localparam logic [2:0] TPW_OFS_CTRL = 3'h0;
    localparam logic [2:0] TPW_OFS_COUNT = 3'h1;
    localparam logic [2:0] TPW_OFS_SCALE = 3'h2;
    localparam logic [2:0] TPW_OFS_BOUND = 3'h3;
    localparam logic [2:0] TPW_OFS_IRQ_STAT = 3'h4;
    localparam logic [2:0] TPW_OFS_IRQ_MASK = 3'h5;

    // Reset values
    localparam logic [7:0] TPW_RST_CTRL = 8'h00;
    localparam logic [7:0] TPW_RST_COUNT = 8'h00;
    localparam logic [7:0] TPW_RST_SCALE = 8'h00;
    localparam logic [7:0] TPW_RST_BOUND = 8'h00;
    localparam logic [0:0] TPW_RST_IRQ = 1'h0;

    // Clock source codes in control bits 7:4
    localparam logic [3:0] TPW_SRC_STOP = 4'h0;
    localparam logic [3:0] TPW_SRC_SYS = 4'h1;
    localparam logic [3:0] TPW_SRC_FAST_RC = 4'h2;
    localparam logic [3:0] TPW_SRC_CRYSTAL = 4'h3;
    localparam logic [3:0] TPW_SRC_SLOW_RC = 4'h4;
    localparam logic [3:0] TPW_SRC_COMP = 4'h5;
    localparam logic [3:0] TPW_SRC_PORT_A_BIT0 = 4'h6;
    localparam logic [3:0] TPW_SRC_PORT_A_BIT4 = 4'h7;

    // Output pin select codes in control bits 3:2
    localparam logic [1:0] TPW_OUT_NONE = 2'h0;
    localparam logic [1:0] TPW_OUT_PORT_A_BIT5 = 2'h1;
    localparam logic [1:0] TPW_OUT_PORT_A_BIT3 = 2'h2;
    localparam logic [1:0] TPW_OUT_PORT_A_BIT4 = 2'h3;

    // Synchroniser lane positions of the asynchronous inputs
    localparam int unsigned TPW_NSYNC = 6;
    localparam int unsigned TPW_LN_FAST_RC = 0;
    localparam int unsigned TPW_LN_SLOW_RC = 1;
    localparam int unsigned TPW_LN_CRYSTAL = 2;
    localparam int unsigned TPW_LN_PORT_A_BIT0 = 3;
    localparam int unsigned TPW_LN_PORT_A_BIT4 = 4;
    localparam int unsigned TPW_LN_COMP = 5;

    // Prescaler terminal counts for 1, 4, 16, 64
    localparam logic [5:0] TPW_PRE_TC1 = 6'h00;
    localparam logic [5:0] TPW_PRE_TC4 = 6'h03;
    localparam logic [5:0] TPW_PRE_TC16 = 6'h0f;
    localparam logic [5:0] TPW_PRE_TC64 = 6'h3f;

    // PWM counter tops for 8, 7 and 6-bit resolution
    localparam logic [7:0] TPW_TOP8 = 8'hff;
    localparam logic [7:0] TPW_TOP7 = 8'h7f;
    localparam logic [7:0] TPW_TOP6 = 8'h3f;

    // Control register layout
    typedef struct packed {
        logic [3:0] src;
        logic [1:0] out_sel;
        logic pwm_en;
        logic rsvd;
    } tpw_ctrl_t;

    // Scaling register layout
    typedef struct packed {
        logic low_res;
        logic [1:0] pre;
        logic [4:0] div;
    } tpw_scale_t;

    // Pin drive group
    typedef struct packed {
        logic port_a_bit5;
        logic port_a_bit3;
        logic port_a_bit4;
    } tpw_pins_t;

endpackage : tpw_pkg

//--- verilog/tpw_timer.sv
// Module: 8-bit up-counting timer with period and PWM output
`timescale 1ns/1ps
`default_nettype none
module tpw_timer
    import tpw_pkg::*;
#(
    parameter bit GATE_OPT = 1'b0,
    parameter bit RES7_OPT = 1'b0
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic [TPW_AW-1:0] i_addr,
    input wire logic [TPW_DW-1:0] i_wr_data,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    output logic [TPW_DW-1:0] o_rd_data,
    // Clock sources and comparator
    input wire logic i_cpu_halt,
    input wire logic i_fast_rc,
    input wire logic i_slow_rc,
    input wire logic i_crystal,
    input wire logic i_port_a_bit0,
    input wire logic i_port_a_bit4,
    input wire logic i_comp_out,
    // Output pins
    output tpw_pins_t o_pin_out,
    output tpw_pins_t o_pin_oe,
    // Interrupt
    output logic o_irq
);

    // Register state
    tpw_ctrl_t ctrl_r;
    tpw_scale_t scale_r;
    logic [7:0] bound_r;
    logic [7:0] count_r;
    logic [0:0] irq_stat_r;
    logic [0:0] irq_mask_r;
    logic [7:0] rd_data_r;
    logic wave_r;
    logic comp_lvl_r;

    // Synchroniser chain and decoded ticks
    logic [TPW_NSYNC-1:0] async_in;
    logic [TPW_NSYNC-1:0] sync1_r;
    logic [TPW_NSYNC-1:0] sync2_r;
    logic [TPW_NSYNC-1:0] sync3_r;
    logic [TPW_NSYNC-1:0] rise;
    logic [TPW_NSYNC-1:0] lvl_r;
    logic src_tick;
    logic [5:0] pre_cnt_r;
    logic [5:0] pre_tc;
    logic pre_tick;
    logic [4:0] div_cnt_r;
    logic timer_tick;
    logic [7:0] top;
    logic at_end;
    logic wrap_evt;
    logic pwm_level;
    logic timer_out;
    logic wr_ctrl;
    logic wr_count;
    logic wr_scale;
    logic wr_bound;
    logic wr_stat;
    logic wr_mask;

    // Prescaler terminal count from the select field
    function automatic logic [5:0] pre_tc_of(input logic [1:0] sel);
        logic [5:0] tc;
        tc = TPW_PRE_TC1;
        case (sel)
            2'h0: tc = TPW_PRE_TC1;
            2'h1: tc = TPW_PRE_TC4;
            2'h2: tc = TPW_PRE_TC16;
            default: tc = TPW_PRE_TC64;
        endcase
        return tc;
    endfunction : pre_tc_of

    // Address decode of the write strobe
    always_comb begin
        wr_ctrl = 1'b0;
        wr_count = 1'b0;
        wr_scale = 1'b0;
        wr_bound = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (i_wr_stb && i_addr == TPW_OFS_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (i_wr_stb && i_addr == TPW_OFS_COUNT) begin
            wr_count = 1'b1;
        end else if (i_wr_stb && i_addr == TPW_OFS_SCALE) begin
            wr_scale = 1'b1;
        end else if (i_wr_stb && i_addr == TPW_OFS_BOUND) begin
            wr_bound = 1'b1;
        end else if (i_wr_stb && i_addr == TPW_OFS_IRQ_STAT) begin
            wr_stat = 1'b1;
        end else if (i_wr_stb && i_addr == TPW_OFS_IRQ_MASK) begin
            wr_mask = 1'b1;
        end
    end

    // Configuration registers
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= tpw_ctrl_t'(TPW_RST_CTRL);
            scale_r <= tpw_scale_t'(TPW_RST_SCALE);
            bound_r <= TPW_RST_BOUND;
            irq_mask_r <= TPW_RST_IRQ;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= tpw_ctrl_t'({i_wr_data[7:1], 1'b0});
            end
            if (wr_scale) begin
                scale_r <= tpw_scale_t'(i_wr_data);
            end
            if (wr_bound) begin
                bound_r <= i_wr_data;
            end
            if (wr_mask) begin
                irq_mask_r <= i_wr_data[0:0];
            end
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_data_r <= 8'h00;
        end else if (!i_rd_stb) begin
            rd_data_r <= 8'h00;
        end else if (i_addr == TPW_OFS_CTRL) begin
            rd_data_r <= ctrl_r;
        end else if (i_addr == TPW_OFS_COUNT) begin
            rd_data_r <= count_r;
        end else if (i_addr == TPW_OFS_SCALE) begin
            rd_data_r <= scale_r;
        end else if (i_addr == TPW_OFS_BOUND) begin
            rd_data_r <= bound_r;
        end else if (i_addr == TPW_OFS_IRQ_STAT) begin
            rd_data_r <= {7'h00, irq_stat_r};
        end else if (i_addr == TPW_OFS_IRQ_MASK) begin
            rd_data_r <= {7'h00, irq_mask_r};
        end else begin
            rd_data_r <= 8'h00;
        end
    end

    assign o_rd_data = rd_data_r;

    // Pin and foreign clock inputs gathered into synchroniser lanes
    always_comb begin
        async_in = '0;
        async_in[TPW_LN_FAST_RC] = i_fast_rc;
        async_in[TPW_LN_SLOW_RC] = i_slow_rc;
        async_in[TPW_LN_CRYSTAL] = i_crystal;
        async_in[TPW_LN_PORT_A_BIT0] = i_port_a_bit0;
        async_in[TPW_LN_PORT_A_BIT4] = i_port_a_bit4;
        async_in[TPW_LN_COMP] = i_comp_out;
    end

    // Three flops per lane; only stages two and three are compared
    genvar gi;
    generate
        for (gi = 0; gi < TPW_NSYNC; gi++) begin : g_sync
            always_ff @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                    lvl_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    // Agreed level; a single-cycle glitch never counts
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        lvl_r[gi] <= sync3_r[gi];
                    end
                end
            end
            assign rise[gi] = sync2_r[gi] & sync3_r[gi] & ~lvl_r[gi];
        end
    endgenerate

    // Comparator level changes only once stages two and three agree
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            comp_lvl_r <= 1'b0;
        end else if (sync2_r[TPW_LN_COMP] == sync3_r[TPW_LN_COMP]) begin
            comp_lvl_r <= sync3_r[TPW_LN_COMP];
        end
    end

    // Source select; a halt freezes every source but the fast RC
    always_comb begin
        src_tick = 1'b0;
        case (ctrl_r.src)
            TPW_SRC_SYS: src_tick = ~i_cpu_halt;
            TPW_SRC_FAST_RC: src_tick = rise[TPW_LN_FAST_RC];
            TPW_SRC_CRYSTAL: src_tick = rise[TPW_LN_CRYSTAL] & ~i_cpu_halt;
            TPW_SRC_SLOW_RC: src_tick = rise[TPW_LN_SLOW_RC] & ~i_cpu_halt;
            TPW_SRC_COMP: src_tick = rise[TPW_LN_COMP] & ~i_cpu_halt;
            TPW_SRC_PORT_A_BIT0: src_tick = rise[TPW_LN_PORT_A_BIT0] & ~i_cpu_halt;
            TPW_SRC_PORT_A_BIT4: src_tick = rise[TPW_LN_PORT_A_BIT4] & ~i_cpu_halt;
            default: src_tick = 1'b0;
        endcase
    end

    // Prescaler divides source ticks by 1, 4, 16 or 64
    assign pre_tc = pre_tc_of(scale_r.pre);
    assign pre_tick = src_tick && (pre_cnt_r >= pre_tc);

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_cnt_r <= 6'h00;
        end else if (pre_tick) begin
            pre_cnt_r <= 6'h00;
        end else if (src_tick) begin
            pre_cnt_r <= pre_cnt_r + 6'h01;
        end
    end

    // Scaler divides by the field value plus one; a lowered value ends the run early
    assign timer_tick = pre_tick && (div_cnt_r >= scale_r.div);

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_cnt_r <= 5'h00;
        end else if (timer_tick) begin
            div_cnt_r <= 5'h00;
        end else if (pre_tick) begin
            div_cnt_r <= div_cnt_r + 5'h01;
        end
    end

    // End of count: bound in period mode, resolution top in PWM mode
    always_comb begin
        top = TPW_TOP8;
        if (scale_r.low_res) begin
            top = RES7_OPT ? TPW_TOP7 : TPW_TOP6;
        end
    end

    assign at_end = ctrl_r.pwm_en ? (count_r == top) : (count_r == bound_r);
    assign wrap_evt = timer_tick && at_end;

    // Counter; a software write wins over a tick in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count_r <= TPW_RST_COUNT;
        end else if (wr_count) begin
            count_r <= i_wr_data;
        end else if (wrap_evt) begin
            count_r <= 8'h00;
        end else if (timer_tick) begin
            count_r <= count_r + 8'h01;
        end
    end

    // Period square wave; two wraps make one output cycle
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wave_r <= 1'b0;
        end else if (ctrl_r.pwm_en) begin
            wave_r <= 1'b0;
        end else if (wrap_evt) begin
            wave_r <= ~wave_r;
        end
    end

    // PWM level from counter against bound, gated by comparator if built in
    assign pwm_level = (count_r <= bound_r) && !(GATE_OPT && comp_lvl_r);
    assign timer_out = ctrl_r.pwm_en ? pwm_level : wave_r;

    // Output routing to one of three pins; unselected pins stay undriven
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pin_out <= '0;
            o_pin_oe <= '0;
        end else begin
            o_pin_out <= '0;
            o_pin_oe <= '0;
            case (ctrl_r.out_sel)
                TPW_OUT_PORT_A_BIT5: begin
                    o_pin_out.port_a_bit5 <= timer_out;
                    o_pin_oe.port_a_bit5 <= 1'b1;
                end
                TPW_OUT_PORT_A_BIT3: begin
                    o_pin_out.port_a_bit3 <= timer_out;
                    o_pin_oe.port_a_bit3 <= 1'b1;
                end
                TPW_OUT_PORT_A_BIT4: begin
                    o_pin_out.port_a_bit4 <= timer_out;
                    o_pin_oe.port_a_bit4 <= 1'b1;
                end
                default: begin
                    o_pin_out <= '0;
                    o_pin_oe <= '0;
                end
            endcase
        end
    end

    // Sticky wrap flag; a new event beats a write-one clear
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_stat_r <= TPW_RST_IRQ;
        end else if (wrap_evt) begin
            irq_stat_r <= 1'b1;
        end else if (wr_stat && i_wr_data[0]) begin
            irq_stat_r <= 1'b0;
        end
    end

    assign o_irq = |(irq_stat_r & irq_mask_r);

endmodule : tpw_timer
`default_nettype wire

//--- dv/tpw_chk_sva.sv
// Checker: bus, pin-enable and interrupt properties of the timer
`timescale 1ns/1ps
`default_nettype none
module tpw_chk
    import tpw_pkg::*;
(
    // Clock, reset and register port
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [TPW_AW-1:0] i_addr,
    input wire logic [TPW_DW-1:0] i_wr_data,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [TPW_DW-1:0] o_rd_data,
    // Pin enables and interrupt
    input wire tpw_pins_t o_pin_oe,
    input wire logic o_irq
);
    tpw_ctrl_t ctrl_r;
    logic mask_r;
    default clocking dcb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);
    // Shadow of software writes, so routing and masking can be predicted
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= '0;
            mask_r <= 1'b0;
        end else if (i_wr_stb && i_addr == TPW_OFS_CTRL) begin
            ctrl_r <= i_wr_data;
        end else if (i_wr_stb && i_addr == TPW_OFS_IRQ_MASK) begin
            mask_r <= i_wr_data[0];
        end
    end
    rd_idle_a: assert property (!$past(i_rd_stb) |-> o_rd_data == '0)
        else $error("read data not zero between reads");
    unmapped_rd_a: assert property (i_rd_stb && i_addr > TPW_OFS_IRQ_MASK |=> o_rd_data == '0)
        else $error("unmapped index read not zero");
    rsvd_bit_a: assert property (i_rd_stb && i_addr == TPW_OFS_CTRL |=> !o_rd_data[0])
        else $error("reserved control bit reads one");
    ctrl_back_a: assert property (i_rd_stb && i_addr == TPW_OFS_CTRL |=>
        o_rd_data[7:1] == ctrl_r[7:1]) else $error("control readback differs");
    cnt_back_a: assert property (i_wr_stb && i_addr == TPW_OFS_COUNT &&
        ctrl_r.src == TPW_SRC_STOP ##1 !i_wr_stb ##1 i_rd_stb && i_addr == TPW_OFS_COUNT
        |=> o_rd_data == $past(i_wr_data, 3)) else $error("stopped counter readback differs");
    oe_dec_a: assert property ($stable(ctrl_r) && ctrl_r == $past(ctrl_r, 2) |->
        o_pin_oe == {ctrl_r.out_sel == TPW_OUT_PORT_A_BIT5, ctrl_r.out_sel == TPW_OUT_PORT_A_BIT3,
        ctrl_r.out_sel == TPW_OUT_PORT_A_BIT4}) else $error("pin enable not as selected");
    oe_one_a: assert property ($onehot0(o_pin_oe))
        else $error("more than one pin driven");
    irq_mask_a: assert property (!mask_r |-> !o_irq)
        else $error("masked interrupt raised");
    irq_c: cover property (o_irq);
    mid_pin_c: cover property ($rose(o_pin_oe.port_a_bit3));
    cnt_rd_c: cover property (i_rd_stb && i_addr == TPW_OFS_COUNT);
endmodule : tpw_chk
bind tpw_timer tpw_chk i_tpw_chk (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
    .o_pin_oe(o_pin_oe), .o_irq(o_irq)
);
`default_nettype wire

//--- dv/tpw_far_model.sv
// Far-side model: source clocks and comparator level seen by the timer
`timescale 1ns/1ps
`default_nettype none
module tpw_far_model (
    // Clock and commands from the bench
    input wire logic i_clk,
    input wire logic i_start,
    input wire logic [5:0] i_mask,
    input wire logic [7:0] i_num,
    input wire logic [3:0] i_half,
    input wire logic i_comp_lvl,
    // Source lanes, in the order of the timer's sync lanes
    output logic [5:0] o_lanes,
    output logic o_busy
);
    logic [5:0] ph_r = '0;
    logic [8:0] edg_r = '0;
    logic [3:0] tmr_r = '0;
    // Burst of whole cycles; lanes stand at 0 between bursts, the comparator lane at the commanded level
    always @(posedge i_clk) begin
        if (i_start) begin
            edg_r <= {i_num, 1'b0};
            tmr_r <= i_half;
        end else if (edg_r != 9'h000 && tmr_r != 4'h0) begin
            tmr_r <= tmr_r - 4'h1;
        end else if (edg_r != 9'h000) begin
            ph_r <= ph_r ^ i_mask;
            edg_r <= edg_r - 9'h001;
            tmr_r <= i_half;
        end
    end
    // Comparator lane also carries the commanded level
    assign o_lanes = {ph_r[5] | i_comp_lvl, ph_r[4:0]};
    assign o_busy = edg_r != 9'h000;
endmodule : tpw_far_model
`default_nettype wire

//--- dv/tb.sv
// Testbench: register access, timing and pin checks of the timer
`timescale 1ns/1ps
`default_nettype none
module tb
    import tpw_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, halt = 1'b0, go = 1'b0, cmp = 1'b0;
    logic [2:0] addr = '0;
    logic [7:0] wd = '0, num = '0, rdata;
    logic [5:0] msk = '0, ln;
    logic [3:0] hf = 4'h1;
    logic busy, irq;
    logic [15:0] hi, per;
    tpw_pins_t pin, oe;
    int err_total = 0;
    int compares = 0;
    int lns [6] = '{0, 2, 1, 5, 3, 4};
    // 20 MHz reference
    always #25 clk = ~clk;
    tpw_timer #(.GATE_OPT(1'b1), .RES7_OPT(1'b0)) i_tpw_timer (
        .i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wr_data(wd), .i_wr_stb(wr_s),
        .i_rd_stb(rd_s), .o_rd_data(rdata), .i_cpu_halt(halt), .i_fast_rc(ln[0]),
        .i_slow_rc(ln[1]), .i_crystal(ln[2]), .i_port_a_bit0(ln[3]), .i_port_a_bit4(ln[4]),
        .i_comp_out(ln[5]), .o_pin_out(pin), .o_pin_oe(oe), .o_irq(irq)
    );
    tpw_far_model i_tpw_far_model (
        .i_clk(clk), .i_start(go), .i_mask(msk), .i_num(num), .i_half(hf),
        .i_comp_lvl(cmp), .o_lanes(ln), .o_busy(busy)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle then one idle cycle, so no strobe is driven twice in a time step
    task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        wr_s <= w;
        rd_s <= r;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        // Read data stands for this cycle only
        @(negedge clk);
        q = rdata;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, 1'b0, a, d, q);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, 1'b1, a, 8'h00, q);
        chk({8'h00, q}, {8'h00, e});
    endtask : rd
    // Source burst, then time for sync and prescale to settle
    task automatic pulse(input logic [5:0] m, input logic [7:0] k);
        msk <= m;
        num <= k;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int n = 0; n < 2000 && (busy || n < 2); n++) @(negedge clk);
        repeat (8) @(posedge clk);
    endtask : pulse
    // High time and period on the masked pins; skips a partial first wave
    task automatic meas(input tpw_pins_t m, output logic [15:0] h, output logic [15:0] p);
        for (int n = 0; n < 3000 && |(pin & m); n++) @(negedge clk);
        for (int n = 0; n < 3000 && !(|(pin & m)); n++) @(negedge clk);
        for (p = 16'h0000; p < 3000 && |(pin & m); p++) @(negedge clk);
        h = p;
        for (p = h; p < 3000 && !(|(pin & m)); p++) @(negedge clk);
        @(posedge clk);
    endtask : meas
    task automatic stop_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    // Watchdog, far beyond the expected run of about 15000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        // Reset values; unmapped write is dropped
        wr(3'h6, 8'hff);
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        wr(TPW_OFS_CTRL, 8'hff);
        rd(TPW_OFS_CTRL, 8'hfe);
        wr(TPW_OFS_SCALE, 8'ha5);
        rd(TPW_OFS_SCALE, 8'ha5);
        for (int s = 1; s < 4; s++) begin
            wr(TPW_OFS_CTRL, {4'h0, 2'(s), 2'b00});
            repeat (3) @(posedge clk);
            chk({13'h0000, oe}, 16'(3'b100 >> (s - 1)));
        end
        wr(TPW_OFS_COUNT, 8'h5a);
        rd(TPW_OFS_COUNT, 8'h5a);
        // Each source counts its own lane only
        wr(TPW_OFS_SCALE, 8'h00);
        wr(TPW_OFS_BOUND, 8'hff);
        for (int i = 0; i < 6; i++) begin
            wr(TPW_OFS_COUNT, 8'h00);
            wr(TPW_OFS_CTRL, {TPW_SRC_FAST_RC + 4'(i), 4'h0});
            pulse(6'h01 << lns[i], 8'd6);
            pulse(~(6'h01 << lns[i]), 8'd3);
            wr(TPW_OFS_CTRL, 8'h00);
            rd(TPW_OFS_COUNT, 8'h06);
        end
        // Halt stops the system source but a slow fast-RC still counts
        halt <= 1'b1;
        wr(TPW_OFS_COUNT, 8'h00);
        wr(TPW_OFS_CTRL, {TPW_SRC_SYS, 4'h0});
        repeat (20) @(posedge clk);
        rd(TPW_OFS_COUNT, 8'h00);
        hf <= 4'h4;
        wr(TPW_OFS_CTRL, {TPW_SRC_FAST_RC, 4'h0});
        pulse(6'h01, 8'd5);
        rd(TPW_OFS_COUNT, 8'h05);
        halt <= 1'b0;
        // Period mode over every prescale code
        wr(TPW_OFS_BOUND, 8'h02);
        wr(TPW_OFS_CTRL, {TPW_SRC_SYS, TPW_OUT_PORT_A_BIT3, 2'b00});
        for (int p = 0; p < 4; p++) begin
            wr(TPW_OFS_SCALE, {1'b0, 2'(p), 5'h01});
            meas(3'b010, hi, per);
            chk(hi, 16'(6 << (2 * p)));
            chk(per, 16'(12 << (2 * p)));
        end
        rd(TPW_OFS_IRQ_STAT, 8'h01);
        chk({15'h0000, irq}, 16'h0000);
        wr(TPW_OFS_IRQ_MASK, 8'h01);
        chk({15'h0000, irq}, 16'h0001);
        wr(TPW_OFS_CTRL, 8'h00);
        repeat (8) @(posedge clk);
        wr(TPW_OFS_IRQ_STAT, 8'h01);
        chk({15'h0000, irq}, 16'h0000);
        // 8-bit then 6-bit PWM
        wr(TPW_OFS_SCALE, 8'h00);
        wr(TPW_OFS_BOUND, 8'h09);
        wr(TPW_OFS_CTRL, {TPW_SRC_SYS, TPW_OUT_PORT_A_BIT3, 2'b10});
        meas(3'b010, hi, per);
        chk(hi, 16'd10);
        chk(per, 16'd256);
        wr(TPW_OFS_SCALE, 8'h80);
        wr(TPW_OFS_BOUND, 8'h1f);
        meas(3'b010, hi, per);
        chk(hi, 16'd32);
        chk(per, 16'd64);
        // Comparator gate, then a full-scale bound
        cmp <= 1'b1;
        repeat (8) @(posedge clk);
        meas(3'b010, hi, per);
        chk(hi, 16'd0);
        cmp <= 1'b0;
        wr(TPW_OFS_BOUND, 8'h3f);
        repeat (8) @(posedge clk);
        meas(3'b010, hi, per);
        chk(hi, 16'd3000);
        // Full-scale level on the other two pins
        wr(TPW_OFS_CTRL, {TPW_SRC_SYS, TPW_OUT_PORT_A_BIT5, 2'b10});
        repeat (3) @(posedge clk);
        chk({13'h0000, pin}, 16'h0004);
        wr(TPW_OFS_CTRL, {TPW_SRC_SYS, TPW_OUT_PORT_A_BIT4, 2'b10});
        repeat (3) @(posedge clk);
        chk({13'h0000, pin}, 16'h0001);
        stop_test();
    end
endmodule : tb
`default_nettype wire
